/* File: bench/ppsg_assertions.sv */
`timescale 1ns/10ps
module ppsg_checker #(
    parameter int NCLK = 6, SW = 8,
    parameter logic [SW-1:0] SENS_HI = 8'h90, SENS_LO = 8'h70
) (
    input wire logic MCLK_I, RESETN_I, SUPPLY_OK_I, ABNORMAL_I, ODD_I,
    input wire logic FRAME_START_INPUT_I, SCAN_DIRECTION_INPUT_I,
    input wire logic [SW-1:0] PANEL_SENSE_INPUT_I,
    input wire logic [NCLK-1:0] GATE_CLOCK_I, GATE_CLOCK_OUTPUTS_O,
    input wire logic ODD_O, EVEN_O, FORWARD_DIRECTION_SELECT_O, SENSE_OK_O,
    input wire logic BACKWARD_DIRECTION_SELECT_O, PANEL_DISCHARGE_OUT_O
);
    wire hi = PANEL_SENSE_INPUT_I >= SENS_HI;
    wire lo = PANEL_SENSE_INPUT_I <= SENS_LO;
    wire gz = GATE_CLOCK_OUTPUTS_O == '0;
    wire fw = FORWARD_DIRECTION_SELECT_O;
    wire bw = BACKWARD_DIRECTION_SELECT_O;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);
    sequence run_s; SUPPLY_OK_I && hi; endsequence
    sequence drop_s; lo; endsequence
    uv_safe_a: assert property (!SUPPLY_OK_I |=> gz && !EVEN_O && !ODD_O && !fw && !bw)
        else $error("outputs not safe under undervoltage");
    sense_set_a: assert property (hi |=> SENSE_OK_O) else $error("sense ok not set");
    sense_clr_a: assert property (lo |=> !SENSE_OK_O) else $error("sense ok not cleared");
    sense_hold_a: assert property (!hi && !lo |=> $stable(SENSE_OK_O))
        else $error("sense ok moved inside band");
    low_sense_a: assert property (SUPPLY_OK_I && lo |=> gz && EVEN_O && !ODD_O)
        else $error("low sense outputs wrong");
    pass_thru_a: assert property (run_s and !ABNORMAL_I |=> !PANEL_DISCHARGE_OUT_O
        && GATE_CLOCK_OUTPUTS_O == $past(GATE_CLOCK_I) && ODD_O == $past(ODD_I)) else $error("no pass");
    abnormal_a: assert property (SUPPLY_OK_I && ABNORMAL_I |=> gz && EVEN_O && !ODD_O)
        else $error("abnormal outputs wrong");
    power_down_a: assert property (run_s ##1 drop_s |=> PANEL_DISCHARGE_OUT_O)
        else $error("discharge not driven");
    dir_latch_a: assert property (SUPPLY_OK_I && $rose(FRAME_START_INPUT_I) |=>
        fw == !$past(SCAN_DIRECTION_INPUT_I) && bw == $past(SCAN_DIRECTION_INPUT_I)) else $error("dir");
    dir_hold_a: assert property ($past(SUPPLY_OK_I) && SUPPLY_OK_I && !$rose(FRAME_START_INPUT_I)
        |=> $stable(fw) && $stable(bw)) else $error("direction moved without frame start");
endmodule
bind ppsg_gate ppsg_checker #(.NCLK(NCLK), .SW(SW), .SENS_HI(SENS_HI), .SENS_LO(SENS_LO)) chk_u (.*);

/* File: bench/ppsg_fsm_model.sv */
`timescale 1ns/10ps
module ppsg_fsm_model (
    input  wire logic       clk_i,
    output logic [5:0]      gclk_o
);
    // one-hot rotation: a stuck or swapped gate bit shows at once
    initial gclk_o = 6'h01;
    always @(posedge clk_i) gclk_o <= {gclk_o[4:0], gclk_o[5]};
endmodule

/* File: bench/ppsg_gate_bench.sv */
`timescale 1ns/10ps
module ppsg_gate_bench;
    logic clk = 0, rst_n = 0, sup = 0, abn = 0, odd = 0, fsi = 0, scan = 0;
    logic [7:0] sense = 8'h10;
    logic [5:0] gclk, gprev, gout;
    logic       fso, eof, oddo, eveno, fwd, bwd, dis, sok;
    int         miscompares = 0, comparisons = 0, cycles = 0;
    always #2.5 clk = ~clk;
    // value the design sampled at the last edge, since the model rotates on it
    always @(posedge clk) gprev <= gclk;
    ppsg_fsm_model fsm_u (.clk_i(clk), .gclk_o(gclk));
    ppsg_gate dut_u (.MCLK_I(clk), .RESETN_I(rst_n), .SUPPLY_OK_I(sup), .PANEL_SENSE_INPUT_I(sense),
        .GATE_CLOCK_I(gclk), .FRAME_START_PULSE_I(gclk[0]), .END_OF_FRAME_I(gclk[1]), .ODD_I(odd),
        .EVEN_I(~odd), .ABNORMAL_I(abn), .FRAME_START_INPUT_I(fsi), .SCAN_DIRECTION_INPUT_I(scan),
        .GATE_CLOCK_OUTPUTS_O(gout), .FRAME_START_PULSE_OUT_O(fso), .END_OF_FRAME_O(eof),
        .ODD_O(oddo), .EVEN_O(eveno), .FORWARD_DIRECTION_SELECT_O(fwd),
        .BACKWARD_DIRECTION_SELECT_O(bwd), .PANEL_DISCHARGE_OUT_O(dis), .SENSE_OK_O(sok));
    task end_sim;
        if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [7:0] s, e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("Error %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task put(input logic s, input logic [7:0] v);
        @(posedge clk); sup <= s; sense <= v;
        @(posedge clk); #1;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            miscompares++;
            end_sim;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1;
        put(0, 8'hA0); chk({gout, fso, eof}, 8'h00);
        chk({eveno, oddo, fwd, bwd, dis}, 8'h00);
        put(1, 8'h10); chk({eveno, oddo, fwd, bwd, dis}, 8'h14);
        @(posedge clk); odd <= 1;
        put(1, 8'h90); chk({sok, oddo, eveno, dis}, 8'h0C);
        chk({gout, fso, eof}, {gprev, gprev[0], gprev[1]});
        put(1, 8'h71); chk(sok, 1'b1);
        @(posedge clk); abn <= 1;
        put(1, 8'h71); chk({gout, eveno, oddo}, 8'h02);
        @(posedge clk); abn <= 0; scan <= 1; fsi <= 1;
        put(1, 8'h90); chk({fwd, bwd}, 2'b01);
        @(posedge clk); scan <= 0; fsi <= 0;
        put(1, 8'h90); chk({fwd, bwd}, 2'b01);
        put(1, 8'h70); chk({sok, dis, eveno, oddo, fwd, bwd}, 8'h19);
        chk({gout, fso, eof}, 8'h00);
        put(0, 8'h70); chk({fwd, bwd, eveno}, 8'h00);
        end_sim;
    end
endmodule

/* File: inc/ppsg_pkg.sv */
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package ppsg_pkg;
    // ------------------------------------------------------------------------
    // power state
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        PPSG_POWER_UP,
        PPSG_RUNNING,
        PPSG_POWER_DOWN
    } ppsg_state_e;

    localparam int          NUM_GATE_CLK   = 6;
    localparam int          SENSE_W        = 8;
    localparam logic [7:0]  SENSE_HI_RST   = 8'h90;
    localparam logic [7:0]  SENSE_LO_RST   = 8'h70;
    localparam logic        SCAN_RST       = 1'b0;
endpackage

/* File: verilog/ppsg_gate.sv */
`timescale 1ns/10ps
module ppsg_gate #(
    parameter int                       NCLK    = ppsg_pkg::NUM_GATE_CLK,
    parameter int                       SW      = ppsg_pkg::SENSE_W,
    parameter logic [SW-1:0]            SENS_HI = ppsg_pkg::SENSE_HI_RST,
    parameter logic [SW-1:0]            SENS_LO = ppsg_pkg::SENSE_LO_RST
) (
    // clock and reset
    input  wire logic                   MCLK_I,
    input  wire logic                   RESETN_I,
    // supply and panel sense
    input  wire logic                   SUPPLY_OK_I,
    input  wire logic [SW-1:0]          PANEL_SENSE_INPUT_I,
    // frame state machine outputs to gate
    input  wire logic [NCLK-1:0]        GATE_CLOCK_I,
    input  wire logic                   FRAME_START_PULSE_I,
    input  wire logic                   END_OF_FRAME_I,
    input  wire logic                   ODD_I,
    input  wire logic                   EVEN_I,
    input  wire logic                   ABNORMAL_I,
    // timing controller inputs
    input  wire logic                   FRAME_START_INPUT_I,
    input  wire logic                   SCAN_DIRECTION_INPUT_I,
    // gated outputs
    output logic [NCLK-1:0]             GATE_CLOCK_OUTPUTS_O,
    output logic                        FRAME_START_PULSE_OUT_O,
    output logic                        END_OF_FRAME_O,
    output logic                        ODD_O,
    output logic                        EVEN_O,
    output logic                        FORWARD_DIRECTION_SELECT_O,
    output logic                        BACKWARD_DIRECTION_SELECT_O,
    output logic                        PANEL_DISCHARGE_OUT_O,
    output logic                        SENSE_OK_O
);
    // ------------------------------------------------------------------------
    // hysteretic sense
    // ------------------------------------------------------------------------
    logic                sense_ok_q;
    logic                sense_ok_d;
    logic                fs_in_q;
    logic                scan_q;
    ppsg_pkg::ppsg_state_e state_q;
    ppsg_pkg::ppsg_state_e state_d;

    // two thresholds so noise near one level cannot chatter the flag
    assign sense_ok_d = sense_ok_q ? (PANEL_SENSE_INPUT_I > SENS_LO)
                                   : (PANEL_SENSE_INPUT_I >= SENS_HI);

    // ------------------------------------------------------------------------
    // power state and decodes
    // ------------------------------------------------------------------------
    wire all_ok    = SUPPLY_OK_I & sense_ok_d;
    wire powering_down = (state_d == ppsg_pkg::PPSG_POWER_DOWN);
    wire discharge = powering_down & ~sense_ok_d;
    wire abnormal  = ABNORMAL_I | discharge;
    wire run       = all_ok & ~abnormal;
    wire fs_rise   = FRAME_START_INPUT_I & ~fs_in_q;
    wire scan_d    = fs_rise ? SCAN_DIRECTION_INPUT_I : scan_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ppsg_pkg::PPSG_POWER_UP:   if (all_ok) state_d = ppsg_pkg::PPSG_RUNNING;
            ppsg_pkg::PPSG_RUNNING:    if (!sense_ok_d) state_d = ppsg_pkg::PPSG_POWER_DOWN;
            ppsg_pkg::PPSG_POWER_DOWN: if (all_ok) state_d = ppsg_pkg::PPSG_RUNNING;
            default:                   state_d = ppsg_pkg::PPSG_POWER_UP;
        endcase
    end

    // ------------------------------------------------------------------------
    // registers, every output straight from a flop
    // ------------------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            sense_ok_q                  <= 1'b0;
            fs_in_q                     <= 1'b0;
            scan_q                      <= ppsg_pkg::SCAN_RST;
            state_q                     <= ppsg_pkg::PPSG_POWER_UP;
            GATE_CLOCK_OUTPUTS_O        <= '0;
            FRAME_START_PULSE_OUT_O     <= 1'b0;
            END_OF_FRAME_O              <= 1'b0;
            ODD_O                       <= 1'b0;
            EVEN_O                      <= 1'b0;
            FORWARD_DIRECTION_SELECT_O  <= 1'b0;
            BACKWARD_DIRECTION_SELECT_O <= 1'b0;
            PANEL_DISCHARGE_OUT_O       <= 1'b0;
            SENSE_OK_O                  <= 1'b0;
        end else begin
            sense_ok_q                  <= sense_ok_d;
            fs_in_q                     <= FRAME_START_INPUT_I;
            scan_q                      <= scan_d;
            state_q                     <= state_d;
            GATE_CLOCK_OUTPUTS_O        <= run ? GATE_CLOCK_I : '0;
            FRAME_START_PULSE_OUT_O     <= run & FRAME_START_PULSE_I;
            END_OF_FRAME_O              <= run & END_OF_FRAME_I;
            // supply low wins; then low sense or abnormal gives power-up pair
            EVEN_O  <= SUPPLY_OK_I & (~sense_ok_d | abnormal | EVEN_I);
            ODD_O   <= run & ODD_I;
            // selects ignore sense: held by latched scan through power-down
            FORWARD_DIRECTION_SELECT_O  <= SUPPLY_OK_I & ~scan_d;
            BACKWARD_DIRECTION_SELECT_O <= SUPPLY_OK_I & scan_d;
            PANEL_DISCHARGE_OUT_O       <= discharge;
            SENSE_OK_O                  <= sense_ok_d;
        end
    end
endmodule
